// ---- atie_top.sv ----
// transmit interrupt enable block: sticky transmit condition flags, their
// enable register, one combined level interrupt and the data-port request.
// assumes condition pulses come from transmit logic on sys_clk_i.
//
// Implementation choices: the AXI4-Lite interface to the registers and the address map.
module atie_top import atie_pkg::*; #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // axi4-lite write
  input wire logic [ADDR_W-1:0] s_axil_awaddr_i,
  input wire logic s_axil_awvalid_i,
  output logic s_axil_awready_o,
  input wire logic [31:0] s_axil_wdata_i,
  input wire logic [3:0] s_axil_wstrb_i,
  input wire logic s_axil_wvalid_i,
  output logic s_axil_wready_o,
  output logic [1:0] s_axil_bresp_o,
  output logic s_axil_bvalid_o,
  input wire logic s_axil_bready_i,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] s_axil_araddr_i,
  input wire logic s_axil_arvalid_i,
  output logic s_axil_arready_o,
  output logic [31:0] s_axil_rdata_o,
  output logic [1:0] s_axil_rresp_o,
  output logic s_axil_rvalid_o,
  input wire logic s_axil_rready_i,
  // transmit condition pulses
  input wire logic frame_begin_evt_i,
  input wire logic word_moved_evt_i,
  input wire logic serializer_release_i,
  input wire logic last_slot_i,
  input wire logic port_error_evt_i,
  input wire logic clock_loss_evt_i,
  input wire logic stray_sync_evt_i,
  input wire logic starvation_evt_i,
  // outputs toward the processor
  output logic tx_irq_out_o,
  output logic tx_service_request_o
);

  atie_reg_if #(.ADDR_W(ADDR_W)) regs ();

  logic [FLAG_W-1:0] transmit_interrupt_enable_r;
  logic [FLAG_W-1:0] status;
  logic [FLAG_W-1:0] set_vec;
  logic [FLAG_W-1:0] clr_vec;
  logic word_set;
  logic en_wr;
  logic st_wr;
  logic err_any;

  // ----------------------------------------
  // bus slave and flags
  // ----------------------------------------
  atie_axil_slave #(.ADDR_W(ADDR_W)) u_slave (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .s_axil_awaddr_i(s_axil_awaddr_i),
    .s_axil_awvalid_i(s_axil_awvalid_i),
    .s_axil_awready_o(s_axil_awready_o),
    .s_axil_wdata_i(s_axil_wdata_i),
    .s_axil_wstrb_i(s_axil_wstrb_i),
    .s_axil_wvalid_i(s_axil_wvalid_i),
    .s_axil_wready_o(s_axil_wready_o),
    .s_axil_bresp_o(s_axil_bresp_o),
    .s_axil_bvalid_o(s_axil_bvalid_o),
    .s_axil_bready_i(s_axil_bready_i),
    .s_axil_araddr_i(s_axil_araddr_i),
    .s_axil_arvalid_i(s_axil_arvalid_i),
    .s_axil_arready_o(s_axil_arready_o),
    .s_axil_rdata_o(s_axil_rdata_o),
    .s_axil_rresp_o(s_axil_rresp_o),
    .s_axil_rvalid_o(s_axil_rvalid_o),
    .s_axil_rready_i(s_axil_rready_i),
    .regs(regs.bus)
  );

  atie_flags #(.W(FLAG_W)) u_flags (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .set_i(set_vec),
    .clr_i(clr_vec),
    .flags_o(status)
  );

  // ----------------------------------------
  // condition set vector
  // ----------------------------------------
  // word move or release
  assign word_set = word_moved_evt_i | serializer_release_i;

  always_comb begin
    set_vec = '0;
    set_vec[BIT_FRAME] = frame_begin_evt_i;
    set_vec[BIT_WORD] = word_set;
    set_vec[BIT_FINAL] = word_set & last_slot_i;
    set_vec[BIT_PORT] = port_error_evt_i;
    set_vec[BIT_CLOCK] = clock_loss_evt_i;
    set_vec[BIT_SYNC] = stray_sync_evt_i;
    set_vec[BIT_STARVE] = starvation_evt_i;
  end

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  always_comb begin
    en_wr = 1'b0;
    st_wr = 1'b0;
    regs.wr_hit = 1'b0;
    if (regs.wr_addr == ADDR_W'(OFS_ENABLE)) begin
      en_wr = regs.wr_stb & regs.wr_strb[0];
      regs.wr_hit = 1'b1;
    end else if (regs.wr_addr == ADDR_W'(OFS_STATUS)) begin
      st_wr = regs.wr_stb & regs.wr_strb[0];
      regs.wr_hit = 1'b1;
    end
  end

  assign clr_vec = st_wr ? (regs.wr_data[FLAG_W-1:0] & FIELD_MASK) : '0;
  assign err_any = |(status & ERROR_MASK);

  always_comb begin
    regs.rd_data = '0;
    regs.rd_hit = 1'b0;
    if (regs.rd_addr == ADDR_W'(OFS_ENABLE)) begin
      regs.rd_data = {24'h00_0000, transmit_interrupt_enable_r};
      regs.rd_hit = 1'b1;
    end else if (regs.rd_addr == ADDR_W'(OFS_STATUS)) begin
      regs.rd_data = {23'h00_0000, err_any, status};
      regs.rd_hit = 1'b1;
    end
  end

  // ----------------------------------------
  // enable register
  // ----------------------------------------
  // cleared by reset, reserved writes dropped
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      transmit_interrupt_enable_r <= EN_RESET;
    end else if (en_wr) begin
      transmit_interrupt_enable_r <= regs.wr_data[FLAG_W-1:0] & FIELD_MASK;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // gated combine
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tx_irq_out_o <= 1'b0;
    end else begin
      tx_irq_out_o <= |(status & transmit_interrupt_enable_r);
    end
  end

  // request ignores the enable; one pulse per set, so back-to-back sets give a level
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tx_service_request_o <= 1'b0;
    end else begin
      tx_service_request_o <= word_set;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!resetn_i);

  // flag lands one edge after the event, interrupt one edge after that
  sequence irq_follows_s;
    ##1 tx_irq_out_o;
  endsequence

  sequence irq_quiet_s;
    ##1 !tx_irq_out_o;
  endsequence

  irq_raised_a: assert property ((|(status & transmit_interrupt_enable_r)) |=> tx_irq_out_o)
    else $error("enabled flag did not raise the interrupt");
  irq_masked_a: assert property ((status & transmit_interrupt_enable_r) == '0 |=> !tx_irq_out_o)
    else $error("interrupt high with no enabled flag");
  frame_gate_a: assert property ((frame_begin_evt_i
    && transmit_interrupt_enable_r[BIT_FRAME] && !en_wr) |=> irq_follows_s)
    else $error("frame start did not raise interrupt");
  word_gate_a: assert property ((word_set
    && transmit_interrupt_enable_r[BIT_WORD] && !en_wr) |=> irq_follows_s)
    else $error("data ready did not raise interrupt");
  final_gate_a: assert property ((status[BIT_FINAL]
    && !transmit_interrupt_enable_r[BIT_FINAL]
    && (status & transmit_interrupt_enable_r) == '0) |=> !tx_irq_out_o)
    else $error("disabled last slot raised interrupt");
  port_gate_a: assert property ((port_error_evt_i
    && transmit_interrupt_enable_r[BIT_PORT] && !en_wr) |=> irq_follows_s)
    else $error("bus error did not raise interrupt");
  clock_gate_a: assert property ((clock_loss_evt_i
    && transmit_interrupt_enable_r[BIT_CLOCK] && !en_wr) |=> irq_follows_s)
    else $error("clock failure did not raise interrupt");
  sync_gate_a: assert property ((stray_sync_evt_i
    && transmit_interrupt_enable_r[BIT_SYNC] && !en_wr) |=> irq_follows_s)
    else $error("stray sync did not raise interrupt");
  starve_gate_a: assert property ((set_vec[BIT_STARVE]
    && !transmit_interrupt_enable_r[BIT_STARVE] && !en_wr
    && ((status | set_vec) & transmit_interrupt_enable_r) == '0) |=> irq_quiet_s)
    else $error("disabled underrun raised interrupt");
  reserved_zero_a: assert property ((regs.rd_addr == ADDR_W'(OFS_ENABLE))
    |-> (regs.rd_data & ~{24'h00_0000, FIELD_MASK}) == '0)
    else $error("reserved enable bits read non-zero");
  reset_clear_a: assert property (@(posedge sys_clk_i) $rose(resetn_i)
    |-> transmit_interrupt_enable_r == EN_RESET)
    else $error("enable register not clear after reset");
  service_req_a: assert property (word_set |=> tx_service_request_o)
    else $error("data ready gave no service request");
  final_slot_a: assert property ((word_set && last_slot_i) |=> status[BIT_FINAL]
    && status[BIT_WORD])
    else $error("last slot flag not set with data ready");

  // ----------------------------------------
  // register checks
  // ----------------------------------------
  // bit 6 must never reach the mask, or a stray flag could drive the line
  en_write_a: assert property (en_wr |=> transmit_interrupt_enable_r ==
    {$past(regs.wr_data[BIT_FRAME]), 1'b0, $past(regs.wr_data[BIT_WORD:0])})
    else $error("enable write landed wrong");
  en_hold_a: assert property (!en_wr |=> $stable(transmit_interrupt_enable_r))
    else $error("enable changed without a write");
  reset_quiet_a: assert property (@(posedge sys_clk_i) $rose(resetn_i)
    |-> status == FLAG_RESET && !tx_irq_out_o && !tx_service_request_o)
    else $error("flags or outputs not clear after reset");

  // ----------------------------------------
  // flag checks
  // ----------------------------------------
  // a clear racing a set must lose, or an event would vanish unseen
  zero_keeps_a: assert property ((st_wr && regs.wr_data[FLAG_W-1:0] == '0)
    |=> (status & $past(status)) == $past(status))
    else $error("writing zero dropped a flag");
  one_clears_a: assert property ((st_wr && set_vec == '0)
    |=> (status & $past(regs.wr_data[FLAG_W-1:0])) == '0)
    else $error("writing one left a flag set");
  clear_quiet_a: assert property ((st_wr && set_vec == '0
    && (status & transmit_interrupt_enable_r & ~regs.wr_data[FLAG_W-1:0]) == '0)
    |=> irq_quiet_s)
    else $error("interrupt stayed after clear");
  set_wins_a: assert property ((st_wr && (set_vec & regs.wr_data[FLAG_W-1:0]) != '0)
    |=> (status & $past(set_vec)) == $past(set_vec))
    else $error("clear beat a set in the same cycle");
  set_wins_irq_a: assert property ((st_wr
    && (set_vec & transmit_interrupt_enable_r & regs.wr_data[FLAG_W-1:0]) != '0)
    |=> irq_follows_s)
    else $error("set in clearing cycle gave no interrupt");
  final_needs_a: assert property ((!(word_set && last_slot_i) && !status[BIT_FINAL])
    |=> !status[BIT_FINAL])
    else $error("last slot flag set without data ready");

  // ----------------------------------------
  // service request checks
  // ----------------------------------------
  // the request bypasses the mask so a data mover is never starved
  req_only_a: assert property (!word_set |=> !tx_service_request_o)
    else $error("service request with no data ready");
  req_unmasked_a: assert property ((word_set
    && !transmit_interrupt_enable_r[BIT_WORD]) |=> tx_service_request_o)
    else $error("masked data ready gave no request");
  moved_word_a: assert property (word_moved_evt_i |=> status[BIT_WORD])
    else $error("word move did not set data ready");
  release_word_a: assert property (serializer_release_i |=> status[BIT_WORD])
    else $error("serializer release did not set data ready");

  // ----------------------------------------
  // per-bit gate checks
  // ----------------------------------------
  // bit 6 has no flag, so it gets no checks
  for (genvar b = 0; b < FLAG_W; b++) begin : g_gate
    if (FIELD_MASK[b]) begin : g_live
      bit_raise_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (status[b] && transmit_interrupt_enable_r[b]) |=> tx_irq_out_o)
        else $error("enabled flag did not raise interrupt");
      bit_mask_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (status == (FLAG_W'(1) << b) && !transmit_interrupt_enable_r[b]) |=> !tx_irq_out_o)
        else $error("disabled flag raised interrupt");
    end
  end

endmodule : atie_top

// ---- atie_pkg.sv ----
// package for the transmit interrupt enable block: register map, field
// positions and reset values. assumes a 32-bit axi4-lite register bus.
package atie_pkg;

  // ----------------------------------------
  // register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OFS_ENABLE = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;

  // ----------------------------------------
  // field positions, shared by enable and status; BIT_ERR_ANY is in status only
  // ----------------------------------------
  localparam int BIT_FRAME = 7;
  localparam int BIT_RSVD = 6;
  localparam int BIT_WORD = 5;
  localparam int BIT_FINAL = 4;
  localparam int BIT_PORT = 3;
  localparam int BIT_CLOCK = 2;
  localparam int BIT_SYNC = 1;
  localparam int BIT_STARVE = 0;
  localparam int BIT_ERR_ANY = 8;
  localparam int FLAG_W = 8;

  // ----------------------------------------
  // masks and reset values
  // ----------------------------------------
  localparam logic [7:0] FIELD_MASK = 8'hBF;
  localparam logic [7:0] ERROR_MASK = 8'h0F;
  localparam logic [7:0] EN_RESET = 8'h00;
  localparam logic [7:0] FLAG_RESET = 8'h00;

  // ----------------------------------------
  // axi responses
  // ----------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : atie_pkg

// ---- atie_reg_if.sv ----
// interface between the bus slave and the register file of the block.
// assumes one clock; wr_stb is a one-cycle pulse, read side is combinational.
interface atie_reg_if #(
  parameter int ADDR_W = 8
);
  logic wr_stb;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_hit;
  logic [ADDR_W-1:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_hit;

  modport bus (
    output wr_stb, wr_addr, wr_data, wr_strb, rd_addr,
    input wr_hit, rd_data, rd_hit
  );
  modport regs (
    input wr_stb, wr_addr, wr_data, wr_strb, rd_addr,
    output wr_hit, rd_data, rd_hit
  );
endinterface : atie_reg_if

// ---- atie_flags.sv ----
// sticky event flags, cleared by writing one, set beats clear.
// assumes set and clear come from logic on the same clock.
module atie_flags import atie_pkg::*; #(
  parameter int W = FLAG_W
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // set and clear vectors
  input wire logic [W-1:0] set_i,
  input wire logic [W-1:0] clr_i,
  // flag state
  output logic [W-1:0] flags_o
);

  // ----------------------------------------
  // per-bit flag
  // ----------------------------------------
  for (genvar i = 0; i < W; i++) begin : g_flag
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        flags_o[i] <= FLAG_RESET[i];
      end else begin
        flags_o[i] <= set_i[i] | (flags_o[i] & ~clr_i[i]);
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  set_beats_clear_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    1'b1 |=> ((flags_o & $past(set_i)) == $past(set_i)))
    else $error("flag lost a set that met a clear");

  clear_needs_one_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    (clr_i == '0) |=> ((flags_o & $past(flags_o)) == $past(flags_o)))
    else $error("flag dropped without a write of one");

endmodule : atie_flags

// ---- atie_axil_slave.sv ----
// axi4-lite slave front end for the register file.
// assumes a master with one write and one read outstanding at most.
module atie_axil_slave import atie_pkg::*; #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // write address and data
  input wire logic [ADDR_W-1:0] s_axil_awaddr_i,
  input wire logic s_axil_awvalid_i,
  output logic s_axil_awready_o,
  input wire logic [31:0] s_axil_wdata_i,
  input wire logic [3:0] s_axil_wstrb_i,
  input wire logic s_axil_wvalid_i,
  output logic s_axil_wready_o,
  // write response
  output logic [1:0] s_axil_bresp_o,
  output logic s_axil_bvalid_o,
  input wire logic s_axil_bready_i,
  // read
  input wire logic [ADDR_W-1:0] s_axil_araddr_i,
  input wire logic s_axil_arvalid_i,
  output logic s_axil_arready_o,
  output logic [31:0] s_axil_rdata_o,
  output logic [1:0] s_axil_rresp_o,
  output logic s_axil_rvalid_o,
  input wire logic s_axil_rready_i,
  // register side
  atie_reg_if.bus regs
);

  logic aw_got_r;
  logic w_got_r;
  logic ar_got_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [ADDR_W-1:0] araddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic wr_go;
  logic b_done;

  assign wr_go = aw_got_r & w_got_r & ~s_axil_bvalid_o;
  assign b_done = s_axil_bvalid_o & s_axil_bready_i;

  assign regs.wr_stb = wr_go;
  assign regs.wr_addr = awaddr_r;
  assign regs.wr_data = wdata_r;
  assign regs.wr_strb = wstrb_r;
  assign regs.rd_addr = araddr_r;

  // ----------------------------------------
  // write address channel
  // ----------------------------------------
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      aw_got_r <= 1'b0;
      s_axil_awready_o <= 1'b0;
      awaddr_r <= '0;
    end else if (s_axil_awready_o && s_axil_awvalid_i) begin
      aw_got_r <= 1'b1;
      s_axil_awready_o <= 1'b0;
      awaddr_r <= s_axil_awaddr_i;
    end else if (b_done) begin
      aw_got_r <= 1'b0;
      s_axil_awready_o <= 1'b1;
    end else if (!aw_got_r && !s_axil_awready_o) begin
      s_axil_awready_o <= 1'b1;
    end
  end

  // ----------------------------------------
  // write data channel
  // ----------------------------------------
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      w_got_r <= 1'b0;
      s_axil_wready_o <= 1'b0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end else if (s_axil_wready_o && s_axil_wvalid_i) begin
      w_got_r <= 1'b1;
      s_axil_wready_o <= 1'b0;
      wdata_r <= s_axil_wdata_i;
      wstrb_r <= s_axil_wstrb_i;
    end else if (b_done) begin
      w_got_r <= 1'b0;
      s_axil_wready_o <= 1'b1;
    end else if (!w_got_r && !s_axil_wready_o) begin
      s_axil_wready_o <= 1'b1;
    end
  end

  // ----------------------------------------
  // write response, one cycle after both halves are held
  // ----------------------------------------
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_axil_bvalid_o <= 1'b0;
      s_axil_bresp_o <= RESP_OKAY;
    end else if (wr_go) begin
      s_axil_bvalid_o <= 1'b1;
      s_axil_bresp_o <= regs.wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (b_done) begin
      s_axil_bvalid_o <= 1'b0;
    end
  end

  // ----------------------------------------
  // read channel, data one cycle after the address
  // ----------------------------------------
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ar_got_r <= 1'b0;
      araddr_r <= '0;
      s_axil_arready_o <= 1'b0;
      s_axil_rvalid_o <= 1'b0;
      s_axil_rdata_o <= '0;
      s_axil_rresp_o <= RESP_OKAY;
    end else if (s_axil_arready_o && s_axil_arvalid_i) begin
      ar_got_r <= 1'b1;
      araddr_r <= s_axil_araddr_i;
      s_axil_arready_o <= 1'b0;
    end else if (ar_got_r) begin
      ar_got_r <= 1'b0;
      s_axil_rvalid_o <= 1'b1;
      s_axil_rdata_o <= regs.rd_hit ? regs.rd_data : '0;
      s_axil_rresp_o <= regs.rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axil_rvalid_o && s_axil_rready_i) begin
      s_axil_rvalid_o <= 1'b0;
      s_axil_arready_o <= 1'b1;
    end else if (!s_axil_rvalid_o && !s_axil_arready_o) begin
      s_axil_arready_o <= 1'b1;
    end
  end

endmodule : atie_axil_slave

// ---- atie_irq_sink.sv ----
// processor-side sink for the transmit interrupt and the service request.
// assumes both inputs are registered outputs of the block on sys_clk_i.
module atie_irq_sink (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // from the block
  input wire logic tx_irq_out_i,
  input wire logic tx_service_request_i,
  // counts for the bench
  output logic [15:0] req_count_o,
  output logic [15:0] irq_rise_count_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic irq_prev_r;

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      req_count_o <= 16'h0000;
    end else if (tx_service_request_i) begin
      req_count_o <= req_count_o + 16'h0001;
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_prev_r <= 1'b0;
      irq_rise_count_o <= 16'h0000;
    end else begin
      irq_prev_r <= tx_irq_out_i;
      if (tx_irq_out_i && !irq_prev_r) begin
        irq_rise_count_o <= irq_rise_count_o + 16'h0001;
      end
    end
  end
endmodule : atie_irq_sink

// ---- atie_top_bench.sv ----
// self-checking bench for atie_top: axi4-lite master, condition pulses and
// queued expectations checked by a monitor process.
// assumes atie_pkg and atie_irq_sink are compiled first.
`define CHK(what, exp, got) begin total_checks++; if ((got) !== (exp)) begin \
  mismatches++; $display("wrong value %s expected %h seen %h", what, exp, got); end end

module atie_top_bench import atie_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic arvalid = 1'b0;
  logic bready = 1'b1;
  logic rready = 1'b1;
  logic [7:0] ev = 8'h00;
  logic ls = 1'b0;
  logic aw_rdy, w_rdy, b_vld, ar_rdy, r_vld, irq, req;
  logic [1:0] b_resp, r_resp;
  logic [31:0] r_data;
  logic [15:0] req_cnt;
  logic [15:0] rise_cnt;
  logic [15:0] exp_rise = 16'h0000;
  logic [15:0] exp_req = 16'h0000;
  logic [1:0] wr_q[$];
  logic [33:0] rd_q[$];
  logic [33:0] e_rd;
  logic [1:0] e_wr;
  int mismatches = 0;
  int total_checks = 0;
  int bits[7] = '{7, 5, 4, 3, 2, 1, 0};

  always #4 sys_clk_i = ~sys_clk_i;

  atie_top dut (
    .sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
    .s_axil_awaddr_i(awaddr), .s_axil_awvalid_i(awvalid), .s_axil_awready_o(aw_rdy),
    .s_axil_wdata_i(wdata), .s_axil_wstrb_i(wstrb), .s_axil_wvalid_i(wvalid),
    .s_axil_wready_o(w_rdy), .s_axil_bresp_o(b_resp), .s_axil_bvalid_o(b_vld),
    .s_axil_bready_i(bready), .s_axil_araddr_i(araddr), .s_axil_arvalid_i(arvalid),
    .s_axil_arready_o(ar_rdy), .s_axil_rdata_o(r_data), .s_axil_rresp_o(r_resp),
    .s_axil_rvalid_o(r_vld), .s_axil_rready_i(rready),
    .frame_begin_evt_i(ev[7]), .word_moved_evt_i(ev[5]), .serializer_release_i(ev[6]),
    .last_slot_i(ls), .port_error_evt_i(ev[3]), .clock_loss_evt_i(ev[2]),
    .stray_sync_evt_i(ev[1]), .starvation_evt_i(ev[0]),
    .tx_irq_out_o(irq), .tx_service_request_o(req)
  );

  atie_irq_sink sink (
    .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .tx_irq_out_i(irq),
    .tx_service_request_i(req), .req_count_o(req_cnt), .irq_rise_count_o(rise_cnt)
  );

  // ----------------------------------------
  // verdict and bus tasks
  // ----------------------------------------
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict

  task automatic timed_out;
    mismatches++;
    give_verdict();
  endtask : timed_out

  // bready stays high throughout, so the answer is taken where it is seen
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] r);
    int n;
    n = 0;
    wr_q.push_back(r);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge sys_clk_i);
      if (awvalid && aw_rdy) awvalid <= 1'b0;
      if (wvalid && w_rdy) wvalid <= 1'b0;
      n++;
      if (n > 50) timed_out();
    end while (!b_vld);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    n = 0;
    rd_q.push_back({r, d});
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge sys_clk_i);
      if (arvalid && ar_rdy) arvalid <= 1'b0;
      n++;
      if (n > 50) timed_out();
    end while (!r_vld);
  endtask : rd

  task automatic pulse(input logic [7:0] v, input logic l);
    @(posedge sys_clk_i);
    ev <= v;
    ls <= l;
    if (v[5] | v[6]) exp_req++;
    @(posedge sys_clk_i);
    ev <= 8'h00;
    ls <= 1'b0;
  endtask : pulse

  task automatic settle;
    repeat (3) @(posedge sys_clk_i);
  endtask : settle

  function automatic logic [31:0] exp_st(input logic [7:0] v, input logic l);
    logic [31:0] s;
    s = {24'h00_0000, v & 8'haf};
    s[BIT_WORD] = v[BIT_WORD] | v[BIT_RSVD];
    s[BIT_FINAL] = s[BIT_WORD] & l;
    s[BIT_ERR_ANY] = |s[3:0];
    return s;
  endfunction : exp_st

  // ----------------------------------------
  // monitor: oldest note against each answer
  // ----------------------------------------
  always @(posedge sys_clk_i) begin
    if (b_vld && bready) begin
      e_wr = wr_q.pop_front();
      `CHK("write response", e_wr, b_resp)
    end
    if (r_vld && rready) begin
      e_rd = rd_q.pop_front();
      `CHK("read answer", e_rd, {r_resp, r_data})
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [7:0] v;
    logic [7:0] en;
    logic [31:0] st;
    logic l;
    void'($urandom(89738));
    repeat (10) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    @(posedge sys_clk_i);
    rd(OFS_ENABLE, 32'h0000_0000, RESP_OKAY);
    rd(OFS_STATUS, 32'h0000_0000, RESP_OKAY);
    `CHK("irq after reset", 1'b0, irq)
    wr(OFS_ENABLE, 32'hffff_ffff, 4'hf, RESP_OKAY);
    rd(OFS_ENABLE, {24'h00_0000, FIELD_MASK}, RESP_OKAY);
    wr(OFS_ENABLE, 32'h0000_0000, 4'h0, RESP_OKAY);
    rd(OFS_ENABLE, {24'h00_0000, FIELD_MASK}, RESP_OKAY);
    wr(8'h0c, 32'h0000_00ff, 4'hf, RESP_SLVERR);
    rd(8'h08, 32'h0000_0000, RESP_SLVERR);
    // each condition masked, then enabled, then cleared
    foreach (bits[i]) begin
      l = (bits[i] == BIT_FINAL);
      v = l ? 8'h20 : (8'h01 << bits[i]);
      st = exp_st(v, l);
      wr(OFS_ENABLE, {24'h00_0000, FIELD_MASK & ~st[7:0]}, 4'hf, RESP_OKAY);
      pulse(v, l);
      settle();
      `CHK("irq masked", 1'b0, irq)
      rd(OFS_STATUS, st, RESP_OKAY);
      wr(OFS_ENABLE, 32'h0000_0001 << bits[i], 4'hf, RESP_OKAY);
      settle();
      `CHK("irq enabled", 1'b1, irq)
      exp_rise++;
      wr(OFS_STATUS, 32'h0000_0000, 4'hf, RESP_OKAY);
      rd(OFS_STATUS, st, RESP_OKAY);
      wr(OFS_STATUS, st, 4'hf, RESP_OKAY);
      settle();
      `CHK("irq cleared", 1'b0, irq)
      rd(OFS_STATUS, 32'h0000_0000, RESP_OKAY);
    end
    // a set in the clearing cycle must survive the clear
    wr(OFS_ENABLE, 32'h0000_0001, 4'hf, RESP_OKAY);
    pulse(8'h01, 1'b0);
    fork
      wr(OFS_STATUS, 32'h0000_0001, 4'hf, RESP_OKAY);
      begin
        repeat (50) begin
          @(posedge sys_clk_i);
          if (awvalid && aw_rdy) break;
        end
        ev <= 8'h01;
        @(posedge sys_clk_i);
        ev <= 8'h00;
      end
    join
    settle();
    rd(OFS_STATUS, 32'h0000_0101, RESP_OKAY);
    `CHK("irq after set wins", 1'b1, irq)
    exp_rise++;
    wr(OFS_STATUS, 32'h0000_0001, 4'hf, RESP_OKAY);
    // random enables and condition mixes
    repeat (16) begin
      en = 8'($urandom) & FIELD_MASK;
      v = 8'($urandom) & 8'hef;
      l = 1'($urandom);
      st = exp_st(v, l);
      wr(OFS_ENABLE, {24'h00_0000, en}, 4'hf, RESP_OKAY);
      pulse(v, l);
      settle();
      `CHK("irq random", |(st[7:0] & en), irq)
      if (|(st[7:0] & en)) exp_rise++;
      rd(OFS_STATUS, st, RESP_OKAY);
      wr(OFS_STATUS, 32'h0000_00ff, 4'hf, RESP_OKAY);
    end
    settle();
    `CHK("service requests", exp_req, req_cnt)
    `CHK("open notes", 0, wr_q.size() + rd_q.size())
    `CHK("irq rises", exp_rise, rise_cnt)
    give_verdict();
  end
endmodule : atie_top_bench
